// ===== verilog/clk_ctrl_pkg.sv
// Package: register map, field layout and reset values of the clock-control slice
`default_nettype none
package clk_ctrl_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int DIV_W = 5;
	localparam int SEL_W = 4;
	localparam int GATE_W = 14;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_PCIE_APB_DIV = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CCIX_APB_SEL = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_CCIX_APB_DIV = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_CLOCK_GATES = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_PLL_WORD_A = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_PLL_WORD_B = 8'h14;

	// Divider word fields
	localparam int DIV_SET_LSB = 0;
	localparam int DIV_APPLIED_LSB = 16;
	localparam logic [DIV_W-1:0] DIV_RESET = 5'h0B;

	// Source select word fields and codes
	localparam int SEL_SET_LSB = 0;
	localparam int SEL_APPLIED_LSB = 8;
	localparam logic [SEL_W-1:0] SEL_REFERENCE = 4'h1;
	localparam logic [SEL_W-1:0] SEL_SYSTEM_PLL = 4'h2;

	// Gate word: bit 3 reserved, all others reset to one
	localparam int GATE_CCIX_APB = 13;
	localparam int GATE_PCIE_APB = 11;
	localparam logic [GATE_W-1:0] GATE_WRITABLE = 14'h3FF7;
	localparam logic [GATE_W-1:0] GATE_RESET = 14'h3FF7;

	// PLL word A fields
	localparam int PLL_EN_BIT = 31;
	localparam int PLL_INDIV_LSB = 20;
	localparam int PLL_INDIV_W = 6;
	localparam int PLL_FEEDBACK_LSB = 8;
	localparam int PLL_FEEDBACK_W = 12;
	localparam int PLL_PASS_BIT = 0;
	localparam logic PLL_EN_RESET = 1'h1;
	localparam logic [PLL_INDIV_W-1:0] PLL_INDIV_RESET = 6'h01;
	localparam logic [PLL_FEEDBACK_W-1:0] PLL_FEEDBACK_RESET = 12'h030;
	localparam logic PLL_PASS_RESET = 1'h0;

	// PLL word B fields
	localparam int PLL_FRACTION_LSB = 0;
	localparam int PLL_FRACTION_W = 24;
	localparam int PLL_POST1_LSB = 24;
	localparam int PLL_POST2_LSB = 28;
	localparam int PLL_POST_W = 3;
	localparam logic [PLL_POST_W-1:0] PLL_POST_RESET = 3'h1;
	localparam logic [PLL_FRACTION_W-1:0] PLL_FRACTION_RESET = 24'h000000;

	typedef enum logic [1:0] {SW_RUN, SW_DRAIN, SW_PARK} switch_state_t;
endpackage : clk_ctrl_pkg
`default_nettype wire

// ===== verilog/clk_gen_if.sv
// Interfaces: divider and source-switch connections inside the clock-control slice
`timescale 1ns/1ns
`default_nettype none
interface clk_div_if;
	import clk_ctrl_pkg::*;
	logic [DIV_W-1:0] setting;
	logic [DIV_W-1:0] applied;
	logic tick;
	modport ctrl (output setting, input applied, input tick);
	modport div (input setting, output applied, output tick);
endinterface : clk_div_if

interface clk_sel_if;
	import clk_ctrl_pkg::*;
	logic [SEL_W-1:0] setting;
	logic [SEL_W-1:0] applied;
	logic refTick;
	logic pllTick;
	logic outTick;
	modport ctrl (output setting, output refTick, output pllTick, input applied, input outTick);
	modport sw (input setting, input refTick, input pllTick, output applied, output outTick);
endinterface : clk_sel_if
`default_nettype wire

// ===== verilog/clk_tick_divider.sv
// Module: divides the ref_clk cycle stream by setting plus one
`timescale 1ns/1ns
`default_nettype none
module clk_tick_divider (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Divider connection
	clk_div_if.div divPort
);
	import clk_ctrl_pkg::*;

	logic [DIV_W-1:0] count_q;
	logic [DIV_W-1:0] applied_q;
	logic tick_q;
	logic wrap;

	assign wrap = (count_q == applied_q);
	assign divPort.applied = applied_q;
	assign divPort.tick = tick_q;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			count_q <= '0;
			tick_q <= 1'b0;
		end else begin
			count_q <= wrap ? '0 : count_q + 1'b1;
			tick_q <= wrap;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			applied_q <= DIV_RESET;
		end else if (wrap) begin
			applied_q <= divPort.setting;
		end
	end
endmodule : clk_tick_divider
`default_nettype wire

// ===== verilog/clk_source_switch.sv
// Module: glitch-free two-way source switch with applied-source readback
`timescale 1ns/1ns
`default_nettype none
module clk_source_switch (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Switch connection
	clk_sel_if.sw selPort
);
	import clk_ctrl_pkg::*;

	switch_state_t state_q;
	logic [SEL_W-1:0] applied_q;
	logic curTick;
	logic validSel;

	assign validSel = (selPort.setting == SEL_REFERENCE) || (selPort.setting == SEL_SYSTEM_PLL);
	assign curTick = (applied_q == SEL_REFERENCE) ? selPort.refTick : selPort.pllTick;
	// Parked cycle keeps both sources off the output
	assign selPort.outTick = (state_q != SW_PARK) && curTick;
	assign selPort.applied = applied_q;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= SW_RUN;
			applied_q <= SEL_SYSTEM_PLL;
		end else begin
			case (state_q)
				SW_RUN: begin
					if (validSel && selPort.setting != applied_q) begin
						state_q <= SW_DRAIN;
					end
				end
				SW_DRAIN: begin
					if (curTick) begin
						state_q <= SW_PARK;
					end
				end
				SW_PARK: begin
					if (validSel) begin
						applied_q <= selPort.setting;
					end
					state_q <= SW_RUN;
				end
				default: begin
					state_q <= SW_RUN;
				end
			endcase
		end
	end
endmodule : clk_source_switch
`default_nettype wire

// ===== verilog/clk_ctrl_regs.sv
// Module: register slice for peripheral clock dividers, source select, gates and PLL word
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module clk_ctrl_regs (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Register port
	input wire logic [clk_ctrl_pkg::ADDR_W-1:0] regAddr,
	input wire logic [clk_ctrl_pkg::DATA_W-1:0] regWriteData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [clk_ctrl_pkg::DATA_W-1:0] regReadData,
	// Clock sources
	input wire logic referenceClockPin,
	input wire logic pllCoreTick,
	// Generated clock enables
	output logic pcieApbClockTick,
	output logic ccixApbClockTick,
	output logic processorClockTick,
	output logic [clk_ctrl_pkg::GATE_W-1:0] gateEnables,
	// PLL settings
	output logic pllGlobalEnable,
	output logic [clk_ctrl_pkg::PLL_INDIV_W-1:0] pllInputDivider,
	output logic [clk_ctrl_pkg::PLL_FEEDBACK_W-1:0] pllFeedbackDivider,
	output logic pllDirectPassthrough,
	output logic [clk_ctrl_pkg::PLL_FRACTION_W-1:0] pllFraction,
	output logic [clk_ctrl_pkg::PLL_POST_W-1:0] pllPostDivider1,
	output logic [clk_ctrl_pkg::PLL_POST_W-1:0] pllPostDivider2
);
	import clk_ctrl_pkg::*;

	// Divider word layout, shared by both divider registers
	function automatic logic [DATA_W-1:0] divWord(input logic [DIV_W-1:0] setting,
			input logic [DIV_W-1:0] applied);
		logic [DATA_W-1:0] w;
		w = '0;
		w[DIV_SET_LSB +: DIV_W] = setting;
		w[DIV_APPLIED_LSB +: DIV_W] = applied;
		return w;
	endfunction : divWord

	// Software-visible state
	logic [DIV_W-1:0] pcieDivSet_q;
	logic [DIV_W-1:0] ccixDivSet_q;
	logic [SEL_W-1:0] ccixSel_q;
	logic [GATE_W-1:0] gates_q;
	logic pll_global_enable_q;
	logic [PLL_INDIV_W-1:0] pllInDiv_q;
	logic [PLL_FEEDBACK_W-1:0] pllFbDiv_q;
	logic pllPass_q;
	logic [PLL_FRACTION_W-1:0] pllFraction_q;
	logic [PLL_POST_W-1:0] pllPost1_q;
	logic [PLL_POST_W-1:0] pllPost2_q;
	logic [DATA_W-1:0] readData_q;

	// Reference pin synchroniser and filter
	logic refSync1_q;
	logic refSync2_q;
	logic refSync3_q;
	logic refLevel_q;
	logic refTick_q;
	logic refAgree;
	logic refRise;

	// Address decode
	logic hitPcieDiv;
	logic hitCcixSel;
	logic hitCcixDiv;
	logic hitGates;
	logic hitPllA;
	logic hitPllB;
	logic [DATA_W-1:0] readWord;

	assign hitPcieDiv = (regAddr == OFS_PCIE_APB_DIV);
	assign hitCcixSel = (regAddr == OFS_CCIX_APB_SEL);
	assign hitCcixDiv = (regAddr == OFS_CCIX_APB_DIV);
	assign hitGates = (regAddr == OFS_CLOCK_GATES);
	assign hitPllA = (regAddr == OFS_PLL_WORD_A);
	assign hitPllB = (regAddr == OFS_PLL_WORD_B);

	// Write strobes per register
	logic wrPcieDiv;
	logic wrCcixSel;
	logic wrCcixDiv;
	logic wrGates;
	logic wrPllA;
	logic wrPllB;

	assign wrPcieDiv = regWrite && hitPcieDiv;
	assign wrCcixSel = regWrite && hitCcixSel;
	assign wrCcixDiv = regWrite && hitCcixDiv;
	assign wrGates = regWrite && hitGates;
	assign wrPllA = regWrite && hitPllA;
	assign wrPllB = regWrite && hitPllB;

	// Generated clock sub-blocks
	clk_div_if pcieDiv ();
	clk_div_if ccixDiv ();
	clk_sel_if ccixSel ();

	assign pcieDiv.setting = pcieDivSet_q;
	assign ccixDiv.setting = ccixDivSet_q;
	assign ccixSel.setting = ccixSel_q;
	assign ccixSel.refTick = refTick_q;
	assign ccixSel.pllTick = ccixDiv.tick;

	clk_tick_divider pcieDivider (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.divPort(pcieDiv)
	);

	clk_tick_divider ccixDivider (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.divPort(ccixDiv)
	);

	clk_source_switch ccixSwitch (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.selPort(ccixSel)
	);

	// Read mux; unmapped and reserved bits read zero
	always_comb begin
		readWord = '0;
		if (hitPcieDiv) begin
			readWord = divWord(pcieDivSet_q, pcieDiv.applied);
		end else if (hitCcixDiv) begin
			readWord = divWord(ccixDivSet_q, ccixDiv.applied);
		end else if (hitCcixSel) begin
			readWord[SEL_SET_LSB +: SEL_W] = ccixSel_q;
			readWord[SEL_APPLIED_LSB +: SEL_W] = ccixSel.applied;
		end else if (hitGates) begin
			readWord[GATE_W-1:0] = gates_q;
		end else if (hitPllA) begin
			readWord[PLL_EN_BIT] = pll_global_enable_q;
			readWord[PLL_INDIV_LSB +: PLL_INDIV_W] = pllInDiv_q;
			readWord[PLL_FEEDBACK_LSB +: PLL_FEEDBACK_W] = pllFbDiv_q;
			readWord[PLL_PASS_BIT] = pllPass_q;
		end else if (hitPllB) begin
			readWord[PLL_FRACTION_LSB +: PLL_FRACTION_W] = pllFraction_q;
			readWord[PLL_POST1_LSB +: PLL_POST_W] = pllPost1_q;
			readWord[PLL_POST2_LSB +: PLL_POST_W] = pllPost2_q;
		end
	end

	// Read data valid only in the cycle after the strobe
	logic [DATA_W-1:0] readData_d;
	assign readData_d = regRead ? readWord : '0;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			readData_q <= '0;
		end else begin
			readData_q <= readData_d;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pcieDivSet_q <= DIV_RESET;
			ccixDivSet_q <= DIV_RESET;
		end else begin
			if (wrPcieDiv) begin
				pcieDivSet_q <= regWriteData[DIV_SET_LSB +: DIV_W];
			end
			if (wrCcixDiv) begin
				ccixDivSet_q <= regWriteData[DIV_SET_LSB +: DIV_W];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ccixSel_q <= SEL_SYSTEM_PLL;
		end else if (wrCcixSel) begin
			ccixSel_q <= regWriteData[SEL_SET_LSB +: SEL_W];
		end
	end

	// gate enables, bit 3 held zero
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			gates_q <= GATE_RESET;
		end else if (wrGates) begin
			gates_q <= regWriteData[GATE_W-1:0] & GATE_WRITABLE;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pll_global_enable_q <= PLL_EN_RESET;
			pllInDiv_q <= PLL_INDIV_RESET;
			pllFbDiv_q <= PLL_FEEDBACK_RESET;
			pllPass_q <= PLL_PASS_RESET;
		end else if (wrPllA) begin
			pll_global_enable_q <= regWriteData[PLL_EN_BIT];
			pllInDiv_q <= regWriteData[PLL_INDIV_LSB +: PLL_INDIV_W];
			pllFbDiv_q <= regWriteData[PLL_FEEDBACK_LSB +: PLL_FEEDBACK_W];
			pllPass_q <= regWriteData[PLL_PASS_BIT];
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pllFraction_q <= PLL_FRACTION_RESET;
			pllPost1_q <= PLL_POST_RESET;
			pllPost2_q <= PLL_POST_RESET;
		end else if (wrPllB) begin
			pllFraction_q <= regWriteData[PLL_FRACTION_LSB +: PLL_FRACTION_W];
			pllPost1_q <= regWriteData[PLL_POST1_LSB +: PLL_POST_W];
			pllPost2_q <= regWriteData[PLL_POST2_LSB +: PLL_POST_W];
		end
	end

	// Reference pin: three stages, level accepted when stages two and three agree
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			refSync1_q <= 1'b0;
			refSync2_q <= 1'b0;
			refSync3_q <= 1'b0;
		end else begin
			refSync1_q <= referenceClockPin;
			refSync2_q <= refSync1_q;
			refSync3_q <= refSync2_q;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			refLevel_q <= 1'b0;
			refTick_q <= 1'b0;
		end else begin
			if (refAgree) begin
				refLevel_q <= refSync2_q;
			end
			refTick_q <= refRise;
		end
	end

	// Accepted reference level and its rising edge
	assign refAgree = (refSync2_q == refSync3_q);
	assign refRise = refAgree && refSync2_q && !refLevel_q;

	// reserved bits ignored via field-only writes, gate bit 3 via the GATE_WRITABLE mask
	assign regReadData = readData_q;
	assign gateEnables = gates_q;

	// Gate bits of the PCIe and CCIX APB clocks made here; the processor clock has none
	logic pcieGateOn;
	logic ccixGateOn;
	assign pcieGateOn = gates_q[GATE_PCIE_APB];
	assign ccixGateOn = gates_q[GATE_CCIX_APB];

	assign pcieApbClockTick = pcieDiv.tick && pcieGateOn;
	assign ccixApbClockTick = ccixSel.outTick && ccixGateOn;

	// enable holds back the PLL output
	logic pllGatedTick;
	assign pllGatedTick = pll_global_enable_q && pllCoreTick;

	assign processorClockTick = pllPass_q ? refTick_q : pllGatedTick;

	assign pllGlobalEnable = pll_global_enable_q;
	assign pllInputDivider = pllInDiv_q;
	assign pllFeedbackDivider = pllFbDiv_q;
	assign pllDirectPassthrough = pllPass_q;
	assign pllFraction = pllFraction_q;
	assign pllPostDivider1 = pllPost1_q;
	assign pllPostDivider2 = pllPost2_q;
endmodule : clk_ctrl_regs
`default_nettype wire

// ===== verif/clk_ctrl_regs_asserts.sv
// Checker: port-level properties of the clock-control register slice
`timescale 1ns/1ns
`default_nettype none
module clk_ctrl_regs_asserts (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Register port
	input wire logic [clk_ctrl_pkg::ADDR_W-1:0] regAddr,
	input wire logic [clk_ctrl_pkg::DATA_W-1:0] regWriteData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [clk_ctrl_pkg::DATA_W-1:0] regReadData,
	// Ticks and settings
	input wire logic pllCoreTick,
	input wire logic pcieApbClockTick,
	input wire logic ccixApbClockTick,
	input wire logic processorClockTick,
	input wire logic [clk_ctrl_pkg::GATE_W-1:0] gateEnables,
	input wire logic pllGlobalEnable,
	input wire logic [clk_ctrl_pkg::PLL_INDIV_W-1:0] pllInputDivider,
	input wire logic [clk_ctrl_pkg::PLL_FEEDBACK_W-1:0] pllFeedbackDivider,
	input wire logic pllDirectPassthrough,
	input wire logic [clk_ctrl_pkg::PLL_FRACTION_W-1:0] pllFraction,
	input wire logic [clk_ctrl_pkg::PLL_POST_W-1:0] pllPostDivider1,
	input wire logic [clk_ctrl_pkg::PLL_POST_W-1:0] pllPostDivider2
);
	import clk_ctrl_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	property p_rdIdle;
		(!regRead || regAddr >= 8'h18) |=> regReadData == 32'h0;
	endproperty
	a_rdIdle: assert property (p_rdIdle) else $error("read data not zero");
	property p_gateRsvd;
		gateEnables[3] == 1'b0;
	endproperty
	a_gateRsvd: assert property (p_gateRsvd) else $error("gate bit 3 set");
	property p_gateWr;
		regWrite && regAddr == 8'h0C |=> gateEnables == ($past(regWriteData[13:0]) & 14'h3FF7);
	endproperty
	a_gateWr: assert property (p_gateWr) else $error("gate write wrong");
	property p_enWr;
		regWrite && regAddr == 8'h10 |=> pllGlobalEnable == $past(regWriteData[31]);
	endproperty
	a_enWr: assert property (p_enWr) else $error("pll enable write wrong");
	property p_divWr;
		regWrite && regAddr == 8'h10 |=> pllFeedbackDivider == $past(regWriteData[19:8])
			&& pllInputDivider == $past(regWriteData[25:20]);
	endproperty
	a_divWr: assert property (p_divWr) else $error("pll divider write wrong");
	property p_passWr;
		regWrite && regAddr == 8'h10 |=> pllDirectPassthrough == $past(regWriteData[0]);
	endproperty
	a_passWr: assert property (p_passWr) else $error("passthrough write wrong");
	property p_proc;
		!pllDirectPassthrough |-> processorClockTick == (pllGlobalEnable && pllCoreTick);
	endproperty
	a_proc: assert property (p_proc) else $error("processor tick wrong");
	property p_pcieGate;
		!gateEnables[11] |-> !pcieApbClockTick;
	endproperty
	a_pcieGate: assert property (p_pcieGate) else $error("gated pcie tick");
	property p_ccixGate;
		!gateEnables[13] |-> !ccixApbClockTick;
	endproperty
	a_ccixGate: assert property (p_ccixGate) else $error("gated ccix tick");
	property p_rst;
		$rose(resetn) |-> pllFeedbackDivider == 12'h030 && pllInputDivider == 6'h01
			&& pllGlobalEnable && !pllDirectPassthrough;
	endproperty
	a_rst: assert property (p_rst) else $error("pll reset values wrong");
	property p_fracWr;
		regWrite && regAddr == 8'h14 |=> pllFraction == $past(regWriteData[23:0]);
	endproperty
	a_fracWr: assert property (p_fracWr) else $error("fraction write wrong");
	property p_postWr;
		regWrite && regAddr == 8'h14 |=> pllPostDivider1 == $past(regWriteData[26:24])
			&& pllPostDivider2 == $past(regWriteData[30:28]);
	endproperty
	a_postWr: assert property (p_postWr) else $error("post divider write wrong");
endmodule : clk_ctrl_regs_asserts
bind clk_ctrl_regs clk_ctrl_regs_asserts chk (.ref_clk, .resetn, .regAddr, .regWriteData,
	.regWrite, .regRead, .regReadData, .pllCoreTick, .pcieApbClockTick, .ccixApbClockTick,
	.processorClockTick, .gateEnables, .pllGlobalEnable, .pllInputDivider,
	.pllFeedbackDivider, .pllDirectPassthrough, .pllFraction, .pllPostDivider1,
	.pllPostDivider2);
`default_nettype wire

// ===== verif/tb_clk_ctrl_regs.sv
// Testbench: register, divider, source switch, gate and PLL word scenarios
`timescale 1ns/1ns
`default_nettype none
module tb_clk_ctrl_regs;
	import clk_ctrl_pkg::*;
	logic ref_clk, resetn, regWrite, regRead, refPin, pllTick, en, pcieTick, ccixTick, procTick;
	logic [ADDR_W-1:0] regAddr;
	logic [DATA_W-1:0] regWriteData, regReadData;
	logic [GATE_W-1:0] gates;
	logic [31:0] n;
	int mismatches = 0;
	int checked = 0;
	int cycles = 0;
	int refCnt = 0;
	clk_ctrl_regs dut (.ref_clk, .resetn, .regAddr, .regWriteData, .regWrite, .regRead,
		.regReadData, .referenceClockPin(refPin), .pllCoreTick(pllTick),
		.pcieApbClockTick(pcieTick), .ccixApbClockTick(ccixTick),
		.processorClockTick(procTick), .gateEnables(gates), .pllGlobalEnable(en),
		.pllInputDivider(), .pllFeedbackDivider(), .pllDirectPassthrough(),
		.pllFraction(), .pllPostDivider1(), .pllPostDivider2());
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	// Reference pin period eight cycles, PLL tick every other cycle
	always @(posedge ref_clk) begin
		refCnt <= refCnt + 1;
		pllTick <= ~pllTick;
		if (refCnt % 4 == 3) refPin <= ~refPin;
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			close_out;
		end
	end
	task chkWord(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL %0t %s got %h expected %h", $time, msg, got, exp);
		end
	endtask : chkWord
	task chkBit(input logic got, input logic exp, input string msg);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL %0t %s got %b", $time, msg, got);
		end
	endtask : chkBit
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWriteData <= d;
		regWrite <= 1'b1;
		@(posedge ref_clk);
		regWrite <= 1'b0;
	endtask : wr
	task rdChk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge ref_clk);
		regRead <= 1'b0;
		#1;
		chkWord(regReadData, exp, "read data");
	endtask : rdChk
	// Cycles from first tick to next; zero if none
	task automatic measure(input int which, output logic [31:0] cnt);
		logic t;
		cnt = 0;
		for (int i = 0; i < 300; i++) begin
			@(negedge ref_clk);
			t = which == 0 ? pcieTick : (which == 1 ? ccixTick : procTick);
			if (t === 1'b1 && cnt != 0) break;
			if (t === 1'b1 || cnt != 0) cnt++;
		end
	endtask : measure
	task t_resetValues;
		rdChk(OFS_PCIE_APB_DIV, 32'h000B000B);
		rdChk(OFS_CCIX_APB_SEL, 32'h00000202);
		rdChk(OFS_CCIX_APB_DIV, 32'h000B000B);
		rdChk(OFS_CLOCK_GATES, 32'h00003FF7);
		rdChk(OFS_PLL_WORD_A, 32'h80103000);
		rdChk(OFS_PLL_WORD_B, 32'h11000000);
		rdChk(8'h40, 32'h00000000);
		$display("reset values done");
	endtask : t_resetValues
	task t_reserved;
		wr(OFS_CLOCK_GATES, 32'hFFFFFFFF);
		wr(OFS_PLL_WORD_A, 32'hFFFFFFFF);
		wr(OFS_PLL_WORD_B, 32'hFFFFFFFF);
		wr(8'h40, 32'hFFFFFFFF);
		rdChk(OFS_CLOCK_GATES, 32'h00003FF7);
		rdChk(OFS_PLL_WORD_A, 32'h83FFFF01);
		rdChk(OFS_PLL_WORD_B, 32'h77FFFFFF);
		rdChk(8'h40, 32'h00000000);
		$display("reserved bits done");
	endtask : t_reserved
	task t_divider;
		measure(0, n);
		chkWord(n, 32'h0000000C, "reset ratio");
		wr(OFS_PCIE_APB_DIV, 32'h001F0003);
		rdChk(OFS_PCIE_APB_DIV, 32'h000B0003);
		repeat (40) @(posedge ref_clk);
		rdChk(OFS_PCIE_APB_DIV, 32'h00030003);
		measure(0, n);
		chkWord(n, 32'h00000004, "ratio four");
		wr(OFS_PCIE_APB_DIV, 32'h00000000);
		repeat (20) @(posedge ref_clk);
		rdChk(OFS_PCIE_APB_DIV, 32'h00000000);
		measure(0, n);
		chkWord(n, 32'h00000001, "undivided");
		wr(OFS_CLOCK_GATES, 32'h000037F7);
		measure(0, n);
		chkWord(n, 32'h00000000, "gated pcie");
		wr(OFS_CLOCK_GATES, 32'h00003FF7);
		$display("divider and gate done");
	endtask : t_divider
	task t_source;
		wr(OFS_CCIX_APB_DIV, 32'h00000000);
		repeat (20) @(posedge ref_clk);
		wr(OFS_CCIX_APB_SEL, 32'h00000001);
		repeat (40) @(posedge ref_clk);
		rdChk(OFS_CCIX_APB_SEL, 32'h00000101);
		measure(1, n);
		chkWord(n, 32'h00000008, "reference source");
		wr(OFS_CCIX_APB_SEL, 32'h00000003);
		repeat (20) @(posedge ref_clk);
		rdChk(OFS_CCIX_APB_SEL, 32'h00000103);
		measure(1, n);
		chkWord(n, 32'h00000008, "code three held");
		wr(OFS_CCIX_APB_SEL, 32'h00000002);
		repeat (40) @(posedge ref_clk);
		rdChk(OFS_CCIX_APB_SEL, 32'h00000202);
		measure(1, n);
		chkWord(n, 32'h00000001, "pll source");
		$display("source switch done");
	endtask : t_source
	task t_pll;
		wr(OFS_PLL_WORD_A, 32'h00103000);
		@(negedge ref_clk);
		chkBit(en, 1'b0, "enable low");
		chkBit(procTick, 1'b0, "pll disabled");
		measure(2, n);
		chkWord(n, 32'h00000000, "pll stays off");
		wr(OFS_PLL_WORD_A, 32'h80103001);
		measure(2, n);
		chkWord(n, 32'h00000008, "passthrough");
		wr(OFS_PLL_WORD_A, 32'h80103000);
		measure(2, n);
		chkWord(n, 32'h00000002, "pll enabled");
		$display("pll word done");
	endtask : t_pll
	task close_out;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out
	initial begin
		resetn = 1'b0;
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = 8'h00;
		regWriteData = 32'h0;
		refPin = 1'b0;
		pllTick = 1'b1;
		repeat (5) @(posedge ref_clk);
		resetn <= 1'b1;
		t_resetValues;
		t_reserved;
		t_divider;
		t_source;
		t_pll;
		close_out;
	end
endmodule : tb_clk_ctrl_regs
`default_nettype wire
